//--- verilog/tmcr_defines.svh
// register offsets, field layout, reset values and control bits of the timer core
// included by the channel, the core and the bench, not by the package or the interface; definitions only
`ifndef TMCR_DEFINES_SVH
`define TMCR_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TMCR_OFS_CTRL 8'h00
`define TMCR_OFS_STAT 8'h04
`define TMCR_OFS_IEN 8'h08
`define TMCR_OFS_ICLR 8'h0c
`define TMCR_OFS_CNT 8'h24
`define TMCR_OFS_DIV 8'h28
`define TMCR_OFS_CAR 8'h2c
`define TMCR_OFS_REP 8'h30
`define TMCR_OFS_CH0 8'h34
`define TMCR_OFS_CH1 8'h38

// ----------------------------------------
// control register bits
// ----------------------------------------
`define TMCR_CTL_CEN 0
`define TMCR_CTL_CH0_ENABLE 1
`define TMCR_CTL_CH0IN 2
`define TMCR_CTL_CH1IN 3
`define TMCR_CTL_CH0SH 4
`define TMCR_CTL_CH1SH 5
`define TMCR_CTL_UPG 6
`define TMCR_CTL_W 7

// ----------------------------------------
// status bits: update, ch0 event, ch1 event
// ----------------------------------------
`define TMCR_ST_UPD 0
`define TMCR_ST_CH0 1
`define TMCR_ST_CH1 2
`define TMCR_ST_W 3

`define TMCR_RST_16 16'h0000
`define TMCR_RST_8 8'h00

`endif

//--- verilog/tmcr_pkg.sv
// types of the timer core
// used with tmcr_defines.svh
package tmcr_pkg;
  typedef logic [15:0] tmcr_val_t;
  typedef enum logic [1:0] {
    TMCR_IDLE,
    TMCR_WR
  } tmcr_bus_e;
endpackage

//--- verilog/tmcr_chan_if.sv
// signals between the core and one capture/compare channel
// driven on mclk
`timescale 1ns/1ns
interface tmcr_chan_if;
  logic [15:0] cnt;
  logic cnt_tick;
  logic upd;
  logic enable;
  logic in_mode;
  logic shadow_en;
  logic wr;
  logic [15:0] wdata;
  logic cap_in;
  logic [15:0] value;
  logic [15:0] active;
  logic event_p;
  modport core (output cnt, cnt_tick, upd, enable, in_mode, shadow_en, wr, wdata, cap_in,
    input value, active, event_p);
  modport chan (input cnt, cnt_tick, upd, enable, in_mode, shadow_en, wr, wdata, cap_in,
    output value, active, event_p);
endinterface

//--- verilog/tmcr_chan.sv
// one capture/compare channel of the timer core
// cap_in is already synchronised to mclk by the core
`timescale 1ns/1ns
`include "tmcr_defines.svh"
module tmcr_chan (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // core side
  tmcr_chan_if.chan ch
);
  logic [15:0] buf_r;
  logic [15:0] act_r;
  logic cap_d_r;
  logic cap_edge;

  assign cap_edge = ch.cap_in && !cap_d_r;
  assign ch.value = ch.in_mode ? act_r : buf_r;
  // the pin compares against the active copy, not the software copy, so shadowing holds back the new value
  assign ch.active = act_r;
  // compare event pulses once on the tick that steps the counter off the match value
  assign ch.event_p = ch.in_mode ? (cap_edge && ch.enable) : (ch.cnt_tick && ch.cnt == act_r);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cap_d_r <= 1'b0;
    end else begin
      cap_d_r <= ch.cap_in;
    end
  end

  // software copy; read-only in input mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      buf_r <= `TMCR_RST_16;
    end else if (ch.wr && !ch.in_mode) begin
      buf_r <= ch.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      act_r <= `TMCR_RST_16;
    end else if (ch.in_mode) begin
      if (cap_edge && ch.enable) begin
        act_r <= ch.cnt;
      end
    end else if (!ch.shadow_en) begin
      if (ch.wr) begin
        act_r <= ch.wdata;
      end
    end else if (ch.upd) begin
      act_r <= buf_r;
    end
  end

  capture_gated_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ch.in_mode && !ch.enable |=> $stable(act_r)) else $error("capture while channel disabled");
  shadow_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !ch.in_mode && ch.shadow_en && !ch.upd |=> $stable(act_r)) else $error("compare moved off update");
  capture_value_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ch.in_mode && ch.enable && cap_edge |=> act_r == $past(ch.cnt)) else $error("capture value wrong");
  cap_seen_c: cover property (@(posedge mclk) disable iff (!reset_n) ch.in_mode && ch.enable && cap_edge);
endmodule

//--- verilog/tmcr_core.sv
// timer core: counter, prescaler, reload, repetition, two capture/compare channels
// ahb-lite slave, single word transfers; capture pins are asynchronous
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`include "tmcr_defines.svh"

module tmcr_core (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // capture inputs
  input wire logic channel0_capture_pin,
  input wire logic channel1_capture_pin,
  // outputs
  output logic channel0_output_pin,
  output logic irq
);
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  tmcr_pkg::tmcr_bus_e bus_st_r;
  logic [7:0] wr_addr_r;
  logic addr_ok;
  logic wr_cyc;
  logic [31:0] rd_nxt;

  // the bus only allows word access to matter here; narrower writes land as words
  assign addr_ok = hsel && hready && htrans[1];
  assign wr_cyc = (bus_st_r == tmcr_pkg::TMCR_WR);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_st_r <= tmcr_pkg::TMCR_IDLE;
      wr_addr_r <= 8'h00;
    end else begin
      if (addr_ok && hwrite) begin
        bus_st_r <= tmcr_pkg::TMCR_WR;
        wr_addr_r <= haddr[7:0];
      end else begin
        bus_st_r <= tmcr_pkg::TMCR_IDLE;
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [`TMCR_CTL_W-1:0] ctrl_r;
  logic [`TMCR_ST_W-1:0] stat_r;
  logic [`TMCR_ST_W-1:0] ien_r;
  tmcr_pkg::tmcr_val_t div_val_r;
  tmcr_pkg::tmcr_val_t div_sh_r;
  tmcr_pkg::tmcr_val_t car_r;
  logic [7:0] rep_r;
  logic [7:0] rep_cnt_r;
  tmcr_pkg::tmcr_val_t cnt_r;
  tmcr_pkg::tmcr_val_t div_r;
  logic sync0_a_r;
  logic sync0_b_r;
  logic sync1_a_r;
  logic sync1_b_r;
  logic tick;
  logic wrap;
  logic upd;
  logic upg;
  logic [`TMCR_ST_W-1:0] ev;

  tmcr_chan_if c0 ();
  tmcr_chan_if c1 ();

  assign upg = wr_cyc && wr_addr_r == `TMCR_OFS_CTRL && hwdata[`TMCR_CTL_UPG];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_r <= '0;
    end else if (wr_cyc && wr_addr_r == `TMCR_OFS_CTRL) begin
      ctrl_r <= hwdata[`TMCR_CTL_W-1:0] & ~(`TMCR_CTL_W'(1) << `TMCR_CTL_UPG);
    end
  end

  // reserved upper bits are dropped on write and read back as zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      div_val_r <= `TMCR_RST_16;
      car_r <= `TMCR_RST_16;
      rep_r <= `TMCR_RST_8;
      ien_r <= '0;
    end else if (wr_cyc) begin
      case (wr_addr_r)
        `TMCR_OFS_DIV: div_val_r <= hwdata[15:0];
        `TMCR_OFS_CAR: car_r <= hwdata[15:0];
        `TMCR_OFS_REP: rep_r <= hwdata[7:0];
        `TMCR_OFS_IEN: ien_r <= hwdata[`TMCR_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // prescaler, counter, repetition
  // ----------------------------------------
  assign tick = ctrl_r[`TMCR_CTL_CEN] && (div_r == div_sh_r);
  assign wrap = tick && (cnt_r == car_r);
  assign upd = (wrap && rep_cnt_r == 8'h00) || upg;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      div_r <= `TMCR_RST_16;
    end else if (upg || tick || !ctrl_r[`TMCR_CTL_CEN]) begin
      div_r <= `TMCR_RST_16;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      div_sh_r <= `TMCR_RST_16;
    end else if (upd) begin
      div_sh_r <= div_val_r;
    end
  end

  // a software write wins over a tick in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_r <= `TMCR_RST_16;
    end else if (wr_cyc && wr_addr_r == `TMCR_OFS_CNT) begin
      cnt_r <= hwdata[15:0];
    end else if (upg || wrap) begin
      cnt_r <= `TMCR_RST_16;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rep_cnt_r <= `TMCR_RST_8;
    end else if (upd) begin
      rep_cnt_r <= rep_r;
    end else if (wrap) begin
      rep_cnt_r <= rep_cnt_r - 8'h01;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync0_a_r <= 1'b0;
      sync0_b_r <= 1'b0;
      sync1_a_r <= 1'b0;
      sync1_b_r <= 1'b0;
    end else begin
      sync0_a_r <= channel0_capture_pin;
      sync0_b_r <= sync0_a_r;
      sync1_a_r <= channel1_capture_pin;
      sync1_b_r <= sync1_a_r;
    end
  end

  assign c0.cnt = cnt_r;
  assign c0.cnt_tick = tick;
  assign c0.upd = upd;
  assign c0.enable = ctrl_r[`TMCR_CTL_CH0_ENABLE];
  assign c0.in_mode = ctrl_r[`TMCR_CTL_CH0IN];
  assign c0.shadow_en = ctrl_r[`TMCR_CTL_CH0SH];
  assign c0.wr = wr_cyc && wr_addr_r == `TMCR_OFS_CH0;
  assign c0.wdata = hwdata[15:0];
  assign c0.cap_in = sync0_b_r;
  // channel 1 has no enable bit in this block, so it always captures
  assign c1.cnt = cnt_r;
  assign c1.cnt_tick = tick;
  assign c1.upd = upd;
  assign c1.enable = 1'b1;
  assign c1.in_mode = ctrl_r[`TMCR_CTL_CH1IN];
  assign c1.shadow_en = ctrl_r[`TMCR_CTL_CH1SH];
  assign c1.wr = wr_cyc && wr_addr_r == `TMCR_OFS_CH1;
  assign c1.wdata = hwdata[15:0];
  assign c1.cap_in = sync1_b_r;

  tmcr_chan u_ch0 (.mclk(mclk), .reset_n(reset_n), .ch(c0.chan));
  tmcr_chan u_ch1 (.mclk(mclk), .reset_n(reset_n), .ch(c1.chan));

  // pwm style: active while count is below the compare value
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      channel0_output_pin <= 1'b0;
    end else begin
      channel0_output_pin <= ctrl_r[`TMCR_CTL_CH0_ENABLE] && !c0.in_mode && (cnt_r < c0.active);
    end
  end

  // ----------------------------------------
  // status and interrupt
  // ----------------------------------------
  assign ev = {c1.event_p, c0.event_p, upd};

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stat_r <= '0;
    end else if (wr_cyc && wr_addr_r == `TMCR_OFS_ICLR) begin
      stat_r <= (stat_r & ~hwdata[`TMCR_ST_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & ien_r);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rd_nxt = 32'h00000000;
    case (haddr[7:0])
      `TMCR_OFS_CTRL: rd_nxt[`TMCR_CTL_W-1:0] = ctrl_r;
      `TMCR_OFS_STAT: rd_nxt[`TMCR_ST_W-1:0] = stat_r;
      `TMCR_OFS_IEN: rd_nxt[`TMCR_ST_W-1:0] = ien_r;
      `TMCR_OFS_CNT: rd_nxt[15:0] = cnt_r;
      `TMCR_OFS_DIV: rd_nxt[15:0] = div_val_r;
      `TMCR_OFS_CAR: rd_nxt[15:0] = car_r;
      `TMCR_OFS_REP: rd_nxt[7:0] = rep_r;
      `TMCR_OFS_CH0: rd_nxt[15:0] = c0.value;
      `TMCR_OFS_CH1: rd_nxt[15:0] = c1.value;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  out_gated_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !ctrl_r[`TMCR_CTL_CH0_ENABLE] |=> !channel0_output_pin) else $error("ch0 active while disabled");
  cnt_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_cyc && wr_addr_r == `TMCR_OFS_CNT |=> cnt_r == $past(hwdata[15:0])) else $error("counter write lost");
  div_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    tick && !upg |=> div_r == 16'h0000) else $error("divider not restarted");
  div_shadow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !upd |=> div_sh_r == $past(div_sh_r)) else $error("divider shadow moved off update");
  wrap_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wrap && !(wr_cyc && wr_addr_r == `TMCR_OFS_CNT) |=> cnt_r == 16'h0000) else $error("no wrap to zero");
  rep_update_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wrap && rep_cnt_r == 8'h00 |-> upd ##1 rep_cnt_r == $past(rep_r)) else $error("repetition reload wrong");
  rep_dec_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wrap && !upd |=> rep_cnt_r == $past(rep_cnt_r) - 8'h01) else $error("repetition not decremented");
  irq_level_a: assert property (@(posedge mclk) disable iff (!reset_n)
    |(stat_r & ien_r) |=> irq) else $error("irq not raised");
  upd_seen_c: cover property (@(posedge mclk) disable iff (!reset_n) upd && !upg);
  pwm_seen_c: cover property (@(posedge mclk) disable iff (!reset_n) $rose(channel0_output_pin));
  irq_seen_c: cover property (@(posedge mclk) disable iff (!reset_n) $rose(irq));
endmodule

//--- sim/tmcr_core_tb.sv
// ----------------------------------------
// self-checking bench of the timer core, driven over its ahb-lite port
// ----------------------------------------
// assumes tmcr_core and tmcr_defines.svh from verilog/ on the include path
`timescale 1ns/1ns
`include "tmcr_defines.svh"
module tmcr_core_tb;
  // ----------------------------------------
  // clock, reset and design ports
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic cap0 = 1'b0;
  logic cap1 = 1'b0;
  logic pin0;
  logic irq;
  logic hung = 1'b0;
  logic done = 1'b0;
  logic seen;
  int miscompares = 0;
  int n_checks = 0;
  int per;
  int hi;
  logic [31:0] rd;
  time t1;
  time t2;

  tmcr_core u_tmcr_core (
    .mclk(mclk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .channel0_capture_pin(cap0),
    .channel1_capture_pin(cap1),
    .channel0_output_pin(pin0),
    .irq(irq)
  );

  initial begin
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang is ended by the watchdog process, so there is no finish here and the caller runs on until then
  task automatic hang();
    miscompares++;
    hung = 1'b1;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_end(input string name);
    $display("test %s done, checks %0d", name, n_checks);
  endtask

  // ----------------------------------------
  // bus cycles: entered just after a rising edge
  // ----------------------------------------
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) hang();
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk_word(q & mask, exp);
  endtask

  // ----------------------------------------
  // pin and interrupt timing
  // ----------------------------------------
  task automatic measure(output int p, output int h);
    int k;
    k = 0;
    h = 0;
    while (pin0 !== 1'b0 && k < 5000) begin @(posedge mclk); k++; end
    while (pin0 !== 1'b1 && k < 5000) begin @(posedge mclk); k++; end
    while (pin0 === 1'b1 && k < 5000) begin @(posedge mclk); k++; h++; end
    p = h;
    while (pin0 !== 1'b1 && k < 5000) begin @(posedge mclk); k++; p++; end
    if (k >= 5000) hang();
  endtask

  task automatic wait_irq(input logic lvl, output time t);
    int k;
    k = 0;
    while (irq !== lvl && k < 500) begin @(posedge mclk); k++; end
    if (irq !== lvl) hang();
    t = $time;
  endtask

  task automatic pulse(input logic ch);
    if (ch) cap1 <= 1'b1;
    else cap0 <= 1'b1;
    repeat (4) @(posedge mclk);
    cap0 <= 1'b0;
    cap1 <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  // overall limit: a run that neither finishes nor reports a hang counts as a mismatch
  initial begin
    int k;
    k = 0;
    while (!hung && !done && k < 50000) begin
      @(posedge mclk);
      k++;
    end
    if (!hung && !done) miscompares++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) rdchk(8'h24 + 8'(4 * i), 32'hffffffff, 32'h0);
    rdchk(`TMCR_OFS_STAT, 32'hffffffff, 32'h0);
    rdchk(8'h50, 32'hffffffff, 32'h0);
    chk_word({31'h0, hresp}, 32'h0);
    test_end("reset");
    wr(`TMCR_OFS_CNT, 32'h1234);
    rdchk(`TMCR_OFS_CNT, 32'hffffffff, 32'h1234);
    wr(`TMCR_OFS_STAT, 32'h7);
    rdchk(`TMCR_OFS_STAT, 32'hffffffff, 32'h0);
    test_end("counter");
    // long repetition keeps hardware updates far apart, so only the software update applies shadows
    wr(`TMCR_OFS_REP, 32'hff);
    wr(`TMCR_OFS_CAR, 32'h3);
    wr(`TMCR_OFS_CH0, 32'h2);
    wr(`TMCR_OFS_CNT, 32'h0);
    wr(`TMCR_OFS_CTRL, 32'h3);
    measure(per, hi);
    chk_num(per, 4);
    chk_num(hi, 2);
    wr(`TMCR_OFS_DIV, 32'h1);
    measure(per, hi);
    chk_num(per, 4);
    wr(`TMCR_OFS_CTRL, 32'h43);
    measure(per, hi);
    measure(per, hi);
    chk_num(per, 8);
    chk_num(hi, 4);
    wr(`TMCR_OFS_CTRL, 32'h13);
    wr(`TMCR_OFS_CH0, 32'h1);
    measure(per, hi);
    chk_num(hi, 4);
    wr(`TMCR_OFS_CTRL, 32'h53);
    measure(per, hi);
    measure(per, hi);
    chk_num(hi, 2);
    wr(`TMCR_OFS_CTRL, 32'h11);
    repeat (3) @(posedge mclk);
    seen = 1'b0;
    repeat (40) begin @(posedge mclk); seen = seen | pin0; end
    chk_word({31'h0, seen}, 32'h0);
    test_end("compare");
    wr(`TMCR_OFS_CTRL, 32'h0);
    wr(`TMCR_OFS_CAR, 32'h3);
    wr(`TMCR_OFS_REP, 32'h2);
    wr(`TMCR_OFS_DIV, 32'h0);
    wr(`TMCR_OFS_CNT, 32'h0);
    wr(`TMCR_OFS_IEN, 32'h1);
    wr(`TMCR_OFS_CTRL, 32'h41);
    wr(`TMCR_OFS_ICLR, 32'h7);
    wait_irq(1'b0, t1);
    wait_irq(1'b1, t1);
    wr(`TMCR_OFS_ICLR, 32'h1);
    wait_irq(1'b0, t2);
    wait_irq(1'b1, t2);
    chk_num(int'((t2 - t1) / 8), 12);
    wr(`TMCR_OFS_IEN, 32'h0);
    repeat (30) @(posedge mclk);
    chk_word({31'h0, irq}, 32'h0);
    rdchk(`TMCR_OFS_STAT, 32'h1, 32'h1);
    wr(`TMCR_OFS_IEN, 32'h1);
    repeat (3) @(posedge mclk);
    chk_word({31'h0, irq}, 32'h1);
    test_end("update");
    wr(`TMCR_OFS_IEN, 32'h0);
    wr(`TMCR_OFS_CTRL, 32'h0);
    wr(`TMCR_OFS_CNT, 32'h0abc);
    wr(`TMCR_OFS_CTRL, 32'he);
    wr(`TMCR_OFS_ICLR, 32'h7);
    pulse(1'b0);
    rdchk(`TMCR_OFS_CH0, 32'hffffffff, 32'h0abc);
    rdchk(`TMCR_OFS_STAT, 32'h2, 32'h2);
    wr(`TMCR_OFS_CH0, 32'h5555);
    rdchk(`TMCR_OFS_CH0, 32'hffffffff, 32'h0abc);
    wr(`TMCR_OFS_CTRL, 32'hc);
    wr(`TMCR_OFS_CNT, 32'h0111);
    wr(`TMCR_OFS_ICLR, 32'h7);
    pulse(1'b0);
    pulse(1'b1);
    rdchk(`TMCR_OFS_CH0, 32'hffffffff, 32'h0abc);
    rdchk(`TMCR_OFS_STAT, 32'h2, 32'h0);
    rdchk(`TMCR_OFS_CH1, 32'hffffffff, 32'h0111);
    test_end("capture");
    done = 1'b1;
  end
endmodule
